// [hw/gpc_pkg.sv]
// constants and types shared by the pin controller files
package gpc_pkg;
  localparam int GPC_PINS = 32;
  localparam int GPC_FUNCS = 4;
  localparam int GPC_GROUP = 8;
  localparam int GPC_GROUPS = 4;

  typedef logic [GPC_PINS-1:0] gpc_word_type;
  typedef logic [GPC_GROUPS-1:0] gpc_irq_type;
  typedef logic [1:0] gpc_code_type;

  localparam gpc_code_type GPC_MODE_CHANGE = 2'h0;
  localparam gpc_code_type GPC_MODE_RISE = 2'h1;
  localparam gpc_code_type GPC_MODE_FALL = 2'h2;
  localparam gpc_code_type GPC_MODE_RSVD = 2'h3;

  localparam gpc_code_type GPC_MUX_FUNC1 = 2'h0;
  localparam gpc_code_type GPC_MUX_FUNC2 = 2'h1;
  localparam gpc_code_type GPC_MUX_FUNC3 = 2'h2;
  localparam gpc_code_type GPC_MUX_FUNC4 = 2'h3;

  localparam gpc_word_type GPC_ZERO = 32'h0000_0000;
  localparam gpc_word_type GPC_LEVEL_RST = 32'h0000_0000;
  localparam gpc_word_type GPC_FLAG_RST = 32'h0000_0000;
  localparam gpc_word_type GPC_SAMPLE_RST = 32'h0000_0000;
  localparam gpc_irq_type GPC_IRQ_RST = 4'h0;
endpackage

// [hw/gpc_det_if.sv]
// bundle between the port logic and the event detector
`timescale 1ns/10ps
interface gpc_det_if #(
  parameter int WIDTH = 32
);
  logic [WIDTH-1:0] sample;
  logic [WIDTH-1:0] filt_en;
  logic [WIDTH-1:0] mode_lo;
  logic [WIDTH-1:0] mode_hi;
  logic [WIDTH-1:0] irq_en;
  logic [WIDTH-1:0] event_hit;

  modport port (output sample, output filt_en, output mode_lo,
                output mode_hi, output irq_en, input event_hit);
  modport det (input sample, input filt_en, input mode_lo,
               input mode_hi, input irq_en, output event_hit);
endinterface

// [hw/gpc_irq_detect.sv]
// per pin glitch filter and edge or change detector
`timescale 1ns/10ps
module gpc_irq_detect
  import gpc_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  gpc_det_if.det    det
);
  logic [WIDTH-1:0] f1_q;
  logic [WIDTH-1:0] flt_q;
  logic [WIDTH-1:0] lvl;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] hit;

  // second capture of the sampled pad
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      f1_q <= '0;
    end else begin
      f1_q <= det.sample;
    end
  end

  // new level only when equal on two consecutive edges
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flt_q <= '0;
    end else begin
      flt_q <= (det.sample & f1_q) | (flt_q & (det.sample | f1_q));
    end
  end

  // filter acts on this path only and lands two cycles late
  assign lvl = (det.filt_en & flt_q)
               | (~det.filt_en & det.sample);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= lvl;
    end
  end

  always_comb begin
    hit = '0;
    for (int i = 0; i < WIDTH; i++) begin
      unique case ({det.mode_hi[i], det.mode_lo[i]})
        GPC_MODE_CHANGE: hit[i] = lvl[i] ^ prev_q[i];
        GPC_MODE_RISE:   hit[i] = lvl[i] & ~prev_q[i];
        GPC_MODE_FALL:   hit[i] = ~lvl[i] & prev_q[i];
        GPC_MODE_RSVD:   hit[i] = 1'b0;
      endcase
    end
  end

  assign det.event_hit = hit & det.irq_en;
endmodule

// [hw/gpc_port.sv]
// one 32-pin general-purpose port: ownership, mux, drive, readback, events
`timescale 1ns/10ps

module gpc_port
  import gpc_pkg::*;
#(
  parameter int PINS = GPC_PINS
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic [PINS-1:0]            pin_ownership_select_i,
  input  wire logic [PINS-1:0]            mux_select_low_i,
  input  wire logic [PINS-1:0]            mux_select_high_i,
  input  wire logic [PINS-1:0]            output_drive_enable_i,
  input  wire logic                       output_level_wr_i,
  input  wire logic [PINS-1:0]            output_level_wdata_i,
  input  wire logic [PINS-1:0]            output_level_set_alias_i,
  input  wire logic [PINS-1:0]            output_level_clear_alias_i,
  input  wire logic [PINS-1:0]            pullup_enable_i,
  input  wire logic [PINS-1:0]            open_drain_enable_i,
  input  wire logic [PINS-1:0]            pin_irq_enable_i,
  input  wire logic [PINS-1:0]            irq_mode_low_i,
  input  wire logic [PINS-1:0]            irq_mode_high_i,
  input  wire logic [PINS-1:0]            glitch_filter_enable_i,
  input  wire logic [PINS-1:0]            pin_irq_flags_clr_i,
  input  wire logic [GPC_FUNCS-1:0][PINS-1:0] periph_oe_i,
  input  wire logic [GPC_FUNCS-1:0][PINS-1:0] periph_out_i,
  input  wire logic [PINS-1:0]            pad_i,
  output logic      [PINS-1:0]            pad_o,
  output logic      [PINS-1:0]            pad_oe_o,
  output logic      [PINS-1:0]            pullup_o,
  output logic      [PINS-1:0]            periph_in_o,
  output logic      [PINS-1:0]            output_level_o,
  output logic      [PINS-1:0]            pin_level_readback_o,
  output logic      [PINS-1:0]            pin_irq_flags_o,
  output logic      [GPC_GROUPS-1:0]      irq_o
);

  // selects the function index from the two mux bits
  function automatic int unsigned func_index(
    input logic hi,
    input logic lo
  );
    int unsigned idx;
    idx = 0;
    unique case ({hi, lo})
      GPC_MUX_FUNC1: idx = 0;
      GPC_MUX_FUNC2: idx = 1;
      GPC_MUX_FUNC3: idx = 2;
      GPC_MUX_FUNC4: idx = 3;
    endcase
    return idx;
  endfunction

  // ors the flagged and enabled pins of one group
  function automatic logic group_or(
    input logic [PINS-1:0] bits,
    input int              grp
  );
    logic acc;
    acc = 1'b0;
    for (int k = 0; k < GPC_GROUP; k++) begin
      acc = acc | bits[grp * GPC_GROUP + k];
    end
    return acc;
  endfunction

  logic [PINS-1:0]       level_q;
  logic [PINS-1:0]       level_d;
  logic [PINS-1:0]       sample_q;
  logic [PINS-1:0]       readback_q;
  logic [PINS-1:0]       flags_q;
  logic [PINS-1:0]       flags_d;
  logic [PINS-1:0]       pad_q;
  logic [PINS-1:0]       pad_d;
  logic [PINS-1:0]       oe_q;
  logic [PINS-1:0]       oe_d;
  logic [PINS-1:0]       pull_q;
  logic [PINS-1:0]       pin_in_q;
  logic [GPC_GROUPS-1:0] irq_q;
  logic [GPC_GROUPS-1:0] irq_d;
  logic [PINS-1:0]       want_oe;
  logic [PINS-1:0]       want_lvl;

  gpc_det_if #(.WIDTH(PINS)) det_bus ();

  // all state below advances only on clock edges
  // a gated clock freezes it, so no events then

  // output level register with direct write and aliases
  always_comb begin
    level_d = level_q;
    if (output_level_wr_i) begin
      level_d = output_level_wdata_i;
    end
    level_d = (level_d | output_level_set_alias_i)
              & ~output_level_clear_alias_i;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_q <= GPC_LEVEL_RST;
    end else begin
      level_q <= level_d;
    end
  end

  // per pin drive decision from owner and open drain
  always_comb begin
    want_oe = '0;
    want_lvl = '0;
    oe_d = '0;
    pad_d = '0;
    for (int i = 0; i < PINS; i++) begin
      if (pin_ownership_select_i[i]) begin
        want_oe[i] = output_drive_enable_i[i];
        want_lvl[i] = level_d[i];
      end else begin
        want_oe[i] = periph_oe_i[func_index(mux_select_high_i[i],
                                 mux_select_low_i[i])][i];
        want_lvl[i] = periph_out_i[func_index(mux_select_high_i[i],
                                   mux_select_low_i[i])][i];
      end
      if (open_drain_enable_i[i]) begin
        oe_d[i] = want_oe[i] & ~want_lvl[i];
        pad_d[i] = 1'b0;
      end else begin
        oe_d[i] = want_oe[i];
        pad_d[i] = want_lvl[i];
      end
    end
  end

  // pad drive flops
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_q <= GPC_ZERO;
      pad_q <= GPC_ZERO;
    end else begin
      oe_q <= oe_d;
      pad_q <= pad_d;
    end
  end

  // pull-up under either owner
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pull_q <= GPC_ZERO;
    end else begin
      pull_q <= pullup_enable_i;
    end
  end

  // pad sampling
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_q <= GPC_SAMPLE_RST;
    end else begin
      sample_q <= pad_i;
    end
  end

  // unfiltered level to the peripherals
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_in_q <= GPC_SAMPLE_RST;
    end else begin
      pin_in_q <= pad_i;
    end
  end

  // readback refreshes only on owned or enabled pins
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      readback_q <= GPC_SAMPLE_RST;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (pin_ownership_select_i[i] | pin_irq_enable_i[i]) begin
          readback_q[i] <= sample_q[i];
        end
      end
    end
  end

  // event detection, filtered or not
  assign det_bus.sample = sample_q;
  assign det_bus.filt_en = glitch_filter_enable_i;
  assign det_bus.mode_lo = irq_mode_low_i;
  assign det_bus.mode_hi = irq_mode_high_i;
  assign det_bus.irq_en = pin_irq_enable_i;

  gpc_irq_detect #(
    .WIDTH (PINS)
  ) u_detect (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .det        (det_bus)
  );

  // sticky flags, a new event beats a same-cycle clear
  always_comb begin
    flags_d = (flags_q & ~pin_irq_flags_clr_i)
              | det_bus.event_hit;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_q <= GPC_FLAG_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // grouped request lines
  always_comb begin
    irq_d = GPC_IRQ_RST;
    for (int g = 0; g < GPC_GROUPS; g++) begin
      irq_d[g] = group_or(flags_d & pin_irq_enable_i, g);
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q <= GPC_IRQ_RST;
    end else begin
      irq_q <= irq_d;
    end
  end

  // outputs
  assign pad_o = pad_q;
  assign pad_oe_o = oe_q;
  assign pullup_o = pull_q;
  assign periph_in_o = pin_in_q;
  assign output_level_o = level_q;
  assign pin_level_readback_o = readback_q;
  assign pin_irq_flags_o = flags_q;
  assign irq_o = irq_q;

endmodule

// [sim/gpc_pad_model.sv]
// board model: resolves each pad from device, external driver and pull-up
`timescale 1ns/10ps
module gpc_pad_model (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [31:0] pad_o_i,
  input  wire logic [31:0] pad_oe_i,
  input  wire logic [31:0] pullup_i,
  input  wire logic [31:0] ext_oe_i,
  input  wire logic [31:0] ext_val_i,
  output logic      [31:0] level_o
);
  logic [31:0] last_q;
  always_ff @(posedge core_clk_i or negedge nrst_i)
    if (!nrst_i)
      last_q <= 32'h0000_0000;
    else
      last_q <= level_o;
  // floating pad without pull-up flips each cycle
  always_comb
    for (int n = 0; n < 32; n++)
      level_o[n] = pad_oe_i[n] ? pad_o_i[n] : ext_oe_i[n] ? ext_val_i[n] :
                   pullup_i[n] | ~last_q[n];
endmodule

// [sim/gpc_port_sva.sv]
// assertions on the pin controller ports
`timescale 1ns/10ps
module gpc_port_sva
  import gpc_pkg::*;
#(
  parameter int PINS = GPC_PINS
) (
  input wire logic                  core_clk_i,
  input wire logic                  nrst_i,
  input wire logic [PINS-1:0]       pin_ownership_select_i,
  input wire logic                  output_level_wr_i,
  input wire logic [PINS-1:0]       output_level_wdata_i,
  input wire logic [PINS-1:0]       output_level_set_alias_i,
  input wire logic [PINS-1:0]       output_level_clear_alias_i,
  input wire logic [PINS-1:0]       pullup_enable_i,
  input wire logic [PINS-1:0]       open_drain_enable_i,
  input wire logic [PINS-1:0]       pin_irq_enable_i,
  input wire logic [PINS-1:0]       pin_irq_flags_clr_i,
  input wire logic [PINS-1:0]       pad_i,
  input wire logic [PINS-1:0]       pad_o,
  input wire logic [PINS-1:0]       pad_oe_o,
  input wire logic [PINS-1:0]       pullup_o,
  input wire logic [PINS-1:0]       periph_in_o,
  input wire logic [PINS-1:0]       output_level_o,
  input wire logic [PINS-1:0]       pin_level_readback_o,
  input wire logic [PINS-1:0]       pin_irq_flags_o,
  input wire logic [GPC_GROUPS-1:0] irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic [GPC_GROUPS-1:0] grp;
  logic [PINS-1:0]       gate;
  always_comb begin
    gate = pin_ownership_select_i | pin_irq_enable_i;
    for (int g = 0; g < GPC_GROUPS; g++)
      grp[g] = |(pin_irq_flags_o[g*GPC_GROUP +: GPC_GROUP] &
                 pin_irq_enable_i[g*GPC_GROUP +: GPC_GROUP]);
  end
  property p_level;
    output_level_o == ((($past(output_level_wr_i) ?
      $past(output_level_wdata_i) : $past(output_level_o)) |
      $past(output_level_set_alias_i)) & ~$past(output_level_clear_alias_i));
  endproperty
  a_level: assert property (p_level) else $error("level wrong");
  property p_pullup; pullup_o == $past(pullup_enable_i); endproperty
  a_pullup: assert property (p_pullup) else $error("pullup wrong");
  property p_periph_in; periph_in_o == $past(pad_i); endproperty
  a_periph_in: assert property (p_periph_in) else $error("pin in");
  property p_open_drain;
    (pad_oe_o & pad_o & $past(open_drain_enable_i)) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin driven high");
  property p_readback;
    (&gate)[*3] |-> pin_level_readback_o == $past(pad_i, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback");
  property p_frozen;
    (gate == '0)[*3] |-> $stable(pin_level_readback_o);
  endproperty
  a_frozen: assert property (p_frozen) else $error("not frozen");
  property p_irq; $stable(pin_irq_enable_i) |-> irq_o == grp; endproperty
  a_irq: assert property (p_irq) else $error("irq line wrong");
  property p_hold;
    ($past(pin_irq_flags_o) & ~$past(pin_irq_flags_clr_i) &
     ~pin_irq_flags_o) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_enabled;
    (pin_irq_flags_o & ~$past(pin_irq_flags_o) &
     ~$past(pin_irq_enable_i)) == '0;
  endproperty
  a_enabled: assert property (p_enabled) else $error("flag off pin");
  c_flag: cover property (|pin_irq_flags_o);
  c_irq: cover property (|irq_o);
  c_frozen: cover property ((gate == '0)[*3]);
endmodule
bind gpc_port gpc_port_sva #(.PINS(PINS)) u_sva (.*);

// [sim/tb_top.sv]
// self-checking bench for the pin controller
`timescale 1ns/10ps
module tb_top;
  import gpc_pkg::*;
  logic                               clk, nrst, wr;
  gpc_word_type                       own, mlo, mhi, ode, wd, set, clr, pu;
  gpc_word_type                       od, ien, iml, imh, gf, fclr, eoe, ev;
  gpc_word_type                       pad, p_o, p_oe, pull, pin, lvl, rb;
  gpc_word_type                       flg, lv, e_oe, e_o;
  gpc_irq_type                        irq;
  logic [GPC_FUNCS-1:0][GPC_PINS-1:0] poe, pout;
  logic [31:0]                        rs;
  int                                 err_count, n_checks, p;
  gpc_port u_dut (
    .core_clk_i(clk), .nrst_i(nrst), .pin_ownership_select_i(own),
    .mux_select_low_i(mlo), .mux_select_high_i(mhi),
    .output_drive_enable_i(ode), .output_level_wr_i(wr),
    .output_level_wdata_i(wd), .output_level_set_alias_i(set),
    .output_level_clear_alias_i(clr), .pullup_enable_i(pu),
    .open_drain_enable_i(od), .pin_irq_enable_i(ien),
    .irq_mode_low_i(iml), .irq_mode_high_i(imh),
    .glitch_filter_enable_i(gf), .pin_irq_flags_clr_i(fclr),
    .periph_oe_i(poe), .periph_out_i(pout), .pad_i(pad), .pad_o(p_o),
    .pad_oe_o(p_oe), .pullup_o(pull), .periph_in_o(pin),
    .output_level_o(lvl), .pin_level_readback_o(rb),
    .pin_irq_flags_o(flg), .irq_o(irq)
  );
  gpc_pad_model u_pad (
    .core_clk_i(clk), .nrst_i(nrst), .pad_o_i(p_o), .pad_oe_i(p_oe),
    .pullup_i(pull), .ext_oe_i(eoe), .ext_val_i(ev), .level_o(pad)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic void exp_pad();
    logic [1:0] k;
    logic       v;
    for (int n = 0; n < GPC_PINS; n++) begin
      k = {mhi[n], mlo[n]};
      v = own[n] ? lv[n] : pout[k][n];
      e_oe[n] = (own[n] ? ode[n] : poe[k][n]) & ~(od[n] & v);
      e_o[n] = v & ~od[n];
    end
  endfunction
  function automatic logic exp_ev(int m, logic up);
    return (m == 0) || (m == 1 && up) || (m == 2 && !up);
  endfunction
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input gpc_word_type e, input gpc_word_type a);
    n_checks++;
    if (a !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic clear_all();
    fclr = '1;
    cyc(1);
    fclr = '0;
  endtask
  task automatic step(logic e, int f);
    gpc_word_type x;
    x = gpc_word_type'(e) << p;
    cyc(1 + 2 * f);
    chk('0, flg);
    cyc(1);
    chk(x, flg);
    chk(gpc_word_type'(e) << (p / GPC_GROUP), 32'(irq));
    cyc(3);
    chk(x, flg);
    fclr = 32'h1 << p;
    cyc(1);
    fclr = '0;
    chk('0, flg);
  endtask
  task automatic glitch(int f, int len, logic e);
    gf = {32{f[0]}};
    cyc(4);
    clear_all();
    ev = '1;
    cyc(len);
    ev = '0;
    cyc(6);
    chk(gpc_word_type'(e) << p, flg);
  endtask
  initial begin
    rs = 32'h0000_71ad;
    {nrst, wr, own, mlo, mhi, ode, wd, set, clr, pu, od} = '0;
    {ien, iml, imh, gf, fclr, ev, poe, pout} = '0;
    eoe = '1;
    err_count = 0;
    n_checks = 0;
    lv = '0;
    cyc(20);
    nrst = 1'b1;
    for (int i = 0; i < 60; i++) begin
      {own, mlo, mhi, ode} = {rnd(), rnd(), rnd(), rnd()};
      {wd, set, pu, od, eoe, ev} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      {poe, pout} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      clr = (i < 8) ? set : rnd();
      wr = rs[3];
      lv = ((wr ? wd : lv) | set) & ~clr;
      exp_pad();
      cyc(1);
      chk(lv, lvl);
      chk(e_oe, p_oe);
      chk(e_o, p_o);
      chk(pu, pull);
    end
    $display("outputs done");
    own = '1;
    ode = '0;
    poe = '0;
    eoe = '1;
    gf = '1;
    ev = rnd();
    cyc(3);
    chk(ev, rb);
    chk(ev, pin);
    lv = ev;
    own = '0;
    cyc(3);
    ev = ~lv;
    cyc(3);
    chk(lv, rb);
    $display("readback done");
    for (int m = 0; m < 4; m++)
      for (int f = 0; f < 2; f++) begin
        p = 8 * m + 7 * f;
        iml = {32{m[0]}};
        imh = {32{m[1]}};
        gf = {32{f[0]}};
        ien = 32'h1 << p;
        ev = '0;
        cyc(6);
        clear_all();
        ev = '1;
        step(exp_ev(m, 1'b1), f);
        ev = '0;
        step(exp_ev(m, 1'b0), f);
      end
    $display("events done");
    iml = '1;
    imh = '0;
    glitch(0, 1, 1'b1);
    glitch(1, 1, 1'b0);
    glitch(1, 2, 1'b1);
    $display("filter done");
    results();
  end
endmodule
